// *** core/port1_mii_input_control.sv ***
// Port 1 media input control: valid, error and reference clock handling
`timescale 1ns/10ps
`default_nettype none
module port1_mii_input_control #(
    parameter int DATA_W = port1_in_pkg::DATA_W
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [2:0] port1_mode_strap,
    input wire logic isolate,
    input wire logic clk_strength,
    input wire logic port1_in_valid,
    input wire logic port1_in_error,
    input wire logic [DATA_W-1:0] port1_in_data_bus,
    input wire logic port1_in_ref_clock_i,
    output logic port1_in_ref_clock_o,
    output logic port1_in_ref_clock_oe_n,
    output logic clk_drive_16ma,
    output logic in_pulldown_en,
    output logic in_buffer_en,
    output logic [DATA_W-1:0] frame_data,
    output logic frame_nibble_mode,
    output logic frame_valid,
    output logic frame_rx_error,
    output logic frame_abort,
    output logic [2:0] port_role
);

    // ------------------------------------------------------------
    // Strap capture and mode decode
    // ------------------------------------------------------------
    logic [2:0] strap_s1_ff, strap_s2_ff, nxt_strap_s2;
    logic strap_done_ff, nxt_strap_done;
    logic strap_sync_ok_ff, strap_arm_ff;
    port1_in_pkg::role_t role_ff, nxt_role;

    // Decode the strap once, after both synchroniser stages hold it
    always_comb begin
        nxt_strap_s2 = strap_s1_ff;
        nxt_strap_done = strap_done_ff | strap_sync_ok_ff;
        nxt_role = role_ff;
        if (strap_sync_ok_ff && !strap_done_ff) begin
            unique case (strap_s2_ff)
                port1_in_pkg::MODE_MII_MAC: nxt_role = port1_in_pkg::ROLE_MII_MAC;
                port1_in_pkg::MODE_MII_PHY: nxt_role = port1_in_pkg::ROLE_MII_PHY;
                port1_in_pkg::MODE_HS_12,
                port1_in_pkg::MODE_HS_16: nxt_role = port1_in_pkg::ROLE_HS_PHY;
                port1_in_pkg::MODE_RMII_A,
                port1_in_pkg::MODE_RMII_B,
                port1_in_pkg::MODE_RMII_C: nxt_role = port1_in_pkg::ROLE_RMII_PHY;
                port1_in_pkg::MODE_INT_PHY: nxt_role = port1_in_pkg::ROLE_INT_PHY;
            endcase
        end
    end

    // Strap synchroniser and latched role
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            strap_s1_ff <= port1_in_pkg::MODE_INT_PHY;
            strap_s2_ff <= port1_in_pkg::MODE_INT_PHY;
            strap_done_ff <= 1'b0;
            role_ff <= port1_in_pkg::ROLE_INT_PHY;
        end else begin
            strap_s1_ff <= port1_mode_strap;
            strap_s2_ff <= nxt_strap_s2;
            strap_done_ff <= nxt_strap_done;
            role_ff <= nxt_role;
        end
    end

    // Wait two cycles so the strap has passed both synchroniser stages
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            strap_arm_ff <= 1'b0;
            strap_sync_ok_ff <= 1'b0;
        end else begin
            strap_arm_ff <= 1'b1;
            strap_sync_ok_ff <= strap_arm_ff;
        end
    end

    logic is_mac, is_mii_phy, is_rmii, is_int, phy_side;
    assign is_mac = (role_ff == port1_in_pkg::ROLE_MII_MAC);
    assign is_mii_phy = (role_ff == port1_in_pkg::ROLE_MII_PHY)
                        || (role_ff == port1_in_pkg::ROLE_HS_PHY);
    assign is_rmii = (role_ff == port1_in_pkg::ROLE_RMII_PHY);
    assign is_int = (role_ff == port1_in_pkg::ROLE_INT_PHY);
    assign phy_side = is_mii_phy | is_rmii;
    assign port_role = role_ff;

    // ------------------------------------------------------------
    // Pad control
    // ------------------------------------------------------------
    // Isolate turns off pull-down and buffer on the PHY side
    assign in_pulldown_en = !(phy_side && isolate);
    assign in_buffer_en = !is_int && !(phy_side && isolate);
    assign clk_drive_16ma = (role_ff == port1_in_pkg::ROLE_HS_PHY) && clk_strength;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [DATA_W+2:0] pin_s1_ff, pin_s2_ff;
    logic clk_prev_ff;

    // Two-stage sync of data, valid, error and external clock
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
            clk_prev_ff <= 1'b0;
        end else begin
            pin_s1_ff <= {port1_in_ref_clock_i, port1_in_error, port1_in_valid,
                          port1_in_data_bus};
            pin_s2_ff <= pin_s1_ff;
            clk_prev_ff <= pin_s2_ff[DATA_W+2];
        end
    end

    // ------------------------------------------------------------
    // Reference clock generator for PHY modes
    // ------------------------------------------------------------
    logic [7:0] div_cnt_ff, nxt_div_cnt;
    logic gen_clk_ff, nxt_gen_clk, gen_rise;

    // Divider toggles the driven clock, rise is one-cycle enable
    always_comb begin
        nxt_div_cnt = div_cnt_ff + port1_in_pkg::CNT_ONE;
        nxt_gen_clk = gen_clk_ff;
        if (div_cnt_ff >= port1_in_pkg::HALF_DIV_CNT - port1_in_pkg::CNT_ONE) begin
            nxt_div_cnt = port1_in_pkg::CNT_ZERO;
            nxt_gen_clk = !gen_clk_ff;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            div_cnt_ff <= port1_in_pkg::CNT_ZERO;
            gen_clk_ff <= 1'b0;
        end else begin
            div_cnt_ff <= nxt_div_cnt;
            gen_clk_ff <= nxt_gen_clk;
        end
    end

    assign gen_rise = nxt_gen_clk && !gen_clk_ff;
    assign port1_in_ref_clock_o = gen_clk_ff;
    assign port1_in_ref_clock_oe_n = !(is_mii_phy && !isolate);

    // ------------------------------------------------------------
    // Input sampling
    // ------------------------------------------------------------
    logic sample_en;
    logic s_valid, s_error;
    logic [DATA_W-1:0] s_data;
    assign s_data = pin_s2_ff[DATA_W-1:0];
    assign s_valid = pin_s2_ff[DATA_W];
    assign s_error = pin_s2_ff[DATA_W+1];

    // Pick the active clock edge per mode; RMII ignores the clock pin
    always_comb begin
        sample_en = 1'b0;
        if (is_mac) begin
            sample_en = pin_s2_ff[DATA_W+2] && !clk_prev_ff;
        end else if (is_mii_phy) begin
            sample_en = gen_rise;
        end else if (is_rmii) begin
            sample_en = gen_rise;
        end
    end

    logic [DATA_W-1:0] fdata_ff, nxt_fdata;
    logic fvalid_ff, nxt_fvalid, ferr_ff, nxt_ferr, fabort_ff, nxt_fabort, nib_ff, nxt_nib;

    // Capture qualified data, error meaning depends on mode
    always_comb begin
        nxt_fdata = fdata_ff;
        nxt_fvalid = 1'b0;
        nxt_ferr = 1'b0;
        nxt_fabort = 1'b0;
        nxt_nib = nib_ff;
        if (sample_en && in_buffer_en && s_valid) begin
            nxt_fvalid = 1'b1;
            if (is_rmii) begin
                nxt_fdata = {{(DATA_W-port1_in_pkg::RMII_W){1'b0}},
                             s_data[port1_in_pkg::RMII_W-1:0]};
                nxt_nib = 1'b0;
            end else begin
                nxt_fdata = s_data;
                nxt_nib = 1'b1;
                nxt_ferr = is_mac && s_error;
                nxt_fabort = is_mii_phy && s_error;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fdata_ff <= '0;
            fvalid_ff <= 1'b0;
            ferr_ff <= 1'b0;
            fabort_ff <= 1'b0;
            nib_ff <= 1'b0;
        end else begin
            fdata_ff <= nxt_fdata;
            fvalid_ff <= nxt_fvalid;
            ferr_ff <= nxt_ferr;
            fabort_ff <= nxt_fabort;
            nib_ff <= nxt_nib;
        end
    end

    assign frame_data = fdata_ff;
    assign frame_valid = fvalid_ff;
    assign frame_rx_error = ferr_ff;
    assign frame_abort = fabort_ff;
    assign frame_nibble_mode = nib_ff;

endmodule
`default_nettype wire

// *** core/port1_in_pkg.sv ***
// Constants for the port 1 media input control block
package port1_in_pkg;
    // Three-bit mode strap encodings
    localparam logic [2:0] MODE_MII_MAC = 3'h0;
    localparam logic [2:0] MODE_MII_PHY = 3'h1;
    localparam logic [2:0] MODE_HS_12 = 3'h2;
    localparam logic [2:0] MODE_HS_16 = 3'h3;
    localparam logic [2:0] MODE_RMII_A = 3'h4;
    localparam logic [2:0] MODE_RMII_B = 3'h5;
    localparam logic [2:0] MODE_RMII_C = 3'h6;
    localparam logic [2:0] MODE_INT_PHY = 3'h7;

    // Decoded port roles
    typedef enum logic [2:0] {
        ROLE_MII_MAC = 3'b000,
        ROLE_MII_PHY = 3'b001,
        ROLE_HS_PHY = 3'b010,
        ROLE_RMII_PHY = 3'b011,
        ROLE_INT_PHY = 3'b100
    } role_t;

    // Data widths
    localparam int DATA_W = 4;
    localparam int RMII_W = 2;

    // Timing: reference clock period in ns and a divider half-period count
    localparam int REF_CLK_NS = 40;
    localparam int MII_CLK_NS = 40;
    localparam int HALF_DIV = (MII_CLK_NS / REF_CLK_NS / 2 < 1) ? 1
                              : MII_CLK_NS / REF_CLK_NS / 2;
    localparam logic [7:0] HALF_DIV_CNT = 8'(HALF_DIV);
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_ONE = 8'h01;
endpackage

// *** tb/port1_in_chk.sv ***
// Port-level assertions for the port 1 input control block
`timescale 1ns/10ps
`default_nettype none
module port1_in_chk #(parameter int DATA_W = port1_in_pkg::DATA_W) (
    input wire logic ref_clk, input wire logic rst, input wire logic isolate,
    input wire logic clk_strength, input wire logic port1_in_valid,
    input wire logic port1_in_ref_clock_i, input wire logic port1_in_ref_clock_oe_n,
    input wire logic clk_drive_16ma, input wire logic in_pulldown_en,
    input wire logic in_buffer_en, input wire logic [DATA_W-1:0] frame_data,
    input wire logic frame_valid, input wire logic frame_rx_error,
    input wire logic frame_abort, input wire logic [2:0] port_role);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_rx_err_mac: assert property (frame_rx_error |-> port_role == 3'h0)
        else $error("rx error off mac");
    a_abort_phy: assert property (frame_abort |-> port_role inside {3'h1, 3'h2})
        else $error("abort off phy");
    a_rmii_low: assert property (frame_valid && port_role == 3'h3
        |-> frame_data[3:2] == 2'h0 && !frame_rx_error && !frame_abort) else $error("rmii");
    a_iso_pads: assert property (isolate && port_role inside {3'h1, 3'h2, 3'h3}
        |-> !in_buffer_en && !in_pulldown_en) else $error("pads on");
    a_iso_clock: assert property (isolate && port_role inside {3'h1, 3'h2}
        |-> port1_in_ref_clock_oe_n) else $error("clock on");
    a_drive_sel: assert property (port_role == 3'h2
        |-> clk_drive_16ma == clk_strength) else $error("strength");
    a_int_idle: assert property (port_role == 3'h4
        |-> !frame_valid && port1_in_ref_clock_oe_n) else $error("internal busy");
    a_mac_sample: assert property (port_role == 3'h0 && $rose(port1_in_ref_clock_i)
        && port1_in_valid |-> ##[2:4] frame_valid) else $error("mac sample lost");
endmodule
bind port1_mii_input_control port1_in_chk #(.DATA_W(DATA_W)) u_chk (.ref_clk, .rst, .isolate,
    .clk_strength, .port1_in_valid, .port1_in_ref_clock_i, .port1_in_ref_clock_oe_n,
    .clk_drive_16ma, .in_pulldown_en, .in_buffer_en, .frame_data, .frame_valid,
    .frame_rx_error, .frame_abort, .port_role);
`default_nettype wire

// *** tb/mii_peer_model.sv ***
// Far-side MAC or PHY model driving the port 1 input pins
`timescale 1ns/10ps
`default_nettype none
module mii_peer_model (
    input wire logic mac_side,
    input wire logic dev_clk,
    output logic lclk,
    output logic dv,
    output logic er,
    output logic [3:0] d
);
    // Idle pins sit at the pull-down level, link clock stands still
    initial {lclk, dv, er, d} = 7'h00;
    // Poll the device clock at falling ref edges; give up after four periods
    task automatic dev_rise();
        logic was;
        for (int i = 0; i < 4; i++) begin
            was = dev_clk;
            #40;
            if (!was && dev_clk) break;
        end
    endtask
    // A PHY sends one unit per link clock; a MAC follows the device clock
    task automatic send(input logic [3:0] v, input logic e);
        if (mac_side) begin
            {dv, er, d} = {1'b1, e, v};
            #160 lclk = 1'b1;
            #160 lclk = 1'b0;
        end else begin
            dev_rise();
            {dv, er, d} = {1'b1, e, v};
            #80;
        end
        {dv, er, d} = 6'h00;
    endtask
endmodule
`default_nettype wire

// *** tb/port1_mii_input_control_tb.sv ***
// Self-checking bench for the port 1 input control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module port1_mii_input_control_tb;
    logic ref_clk = 1'b0, rst = 1'b1, iso = 1'b0, stren = 1'b0;
    logic lclk, dv, er, oe_n, pd, bufe, drv, nib, fv, rxe, abt, clk_o, pin_clk;
    logic [2:0] strap = 3'h0, role, cap_f;
    logic [3:0] d, fd, cap_d;
    int error_cnt = 0, tests_run = 0, cap_n = 0, clk_rises = 0;
    always #20 ref_clk = ~ref_clk;
    // Released clock pin falls to its pull-down level
    assign pin_clk = oe_n ? 1'b0 : clk_o;
    always @(posedge pin_clk) clk_rises++;
    mii_peer_model u_peer (.mac_side(strap == 3'h0), .dev_clk(pin_clk), .lclk, .dv, .er, .d);
    port1_mii_input_control u_dut (.ref_clk, .rst, .port1_mode_strap(strap), .isolate(iso),
        .clk_strength(stren), .port1_in_valid(dv), .port1_in_error(er), .port1_in_data_bus(d),
        .port1_in_ref_clock_i(lclk), .port1_in_ref_clock_o(clk_o), .port1_in_ref_clock_oe_n(oe_n),
        .clk_drive_16ma(drv), .in_pulldown_en(pd), .in_buffer_en(bufe), .frame_data(fd),
        .frame_nibble_mode(nib), .frame_valid(fv), .frame_rx_error(rxe), .frame_abort(abt),
        .port_role(role));
    // Latch each accepted sample and its flags
    always @(posedge ref_clk) begin
        if (fv === 1'b1) {cap_n, cap_d, cap_f} = {cap_n + 1, fd, nib, abt, rxe};
    end
    task automatic finish_test();
        $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic boot(input logic [2:0] m, input logic [2:0] r);
        {strap, iso, rst} = {m, 2'b01};
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        repeat (5) @(negedge ref_clk);
        `CHK("role", r, role)
    endtask
    task automatic xfer(input logic [3:0] v, input logic e, input logic s);
        cap_n = 0;
        u_peer.send(v, e);
        repeat (5) @(negedge ref_clk);
        `CHK("sampled", s, cap_n)
    endtask
    task automatic t_mac();
        boot(3'h0, 3'h0);
        xfer(4'hA, 1'b0, 1'b1);
        `CHK("mac", 8'hD4, {oe_n, cap_d, cap_f})
        xfer(4'h5, 1'b1, 1'b1);
        `CHK("mac err", 7'h2D, {cap_d, cap_f})
        $display("end mac");
    endtask
    task automatic t_phy();
        boot(3'h1, 3'h1);
        clk_rises = 0;
        repeat (8) @(negedge ref_clk);
        `CHK("clock rises", 8 / (2 * port1_in_pkg::HALF_DIV), clk_rises)
        xfer(4'hC, 1'b1, 1'b1);
        `CHK("phy", 8'h66, {oe_n, cap_d, cap_f})
        iso = 1'b1;
        @(negedge ref_clk);
        `CHK("iso pads", 3'h4, {oe_n, pd, bufe})
        clk_rises = 0;
        repeat (8) @(negedge ref_clk);
        `CHK("iso clock", 0, clk_rises)
        xfer(4'h3, 1'b0, 1'b0);
        $display("end phy");
    endtask
    // Remaining strap codes: 200 Mbps strength, RMII dibits, internal
    task automatic t_sweep();
        for (int m = 2; m < 8; m++) begin
            boot(3'(m), (m < 4) ? 3'h2 : (m < 7) ? 3'h3 : 3'h4);
            stren = m[0];
            @(negedge ref_clk);
            if (m < 4) begin
                `CHK("strength", m[0], drv)
            end else begin
                xfer(4'hF, 1'b1, m < 7);
                if (m < 7) `CHK("rmii", 7'h18, {cap_d, cap_f})
            end
        end
        $display("end sweep");
    endtask
    initial begin
        t_mac();
        t_phy();
        t_sweep();
        finish_test();
    end
    // Watchdog far beyond the few microseconds the tests need
    initial begin
        #50000;
        error_cnt++;
        finish_test();
    end
endmodule
`default_nettype wire
